/* common/ipf_pkg.sv */
/*
 * Package for the interrupt priority field block: register offsets,
 * field positions, reset values and the carrier types.
 * Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
 */
`default_nettype none

package ipf_pkg;

    // ------------------------------------------------------------------
    // bus geometry and register map
    // ------------------------------------------------------------------
    localparam int IPF_ADDR_W = 4;
    localparam int IPF_DATA_W = 32;
    localparam int IPF_REG_W = 16;
    localparam int IPF_PRIO_W = 3;
    localparam int IPF_NSRC = 6;

    localparam logic [IPF_ADDR_W-1:0] IPF_OFS_SPI3_UART4 = 4'h0;
    localparam logic [IPF_ADDR_W-1:0] IPF_OFS_CAPCMP9 = 4'h4;

    // ------------------------------------------------------------------
    // field positions (low bit of each 3-bit field)
    // ------------------------------------------------------------------
    localparam int IPF_LSB_SPI3_EVENT = 12;
    localparam int IPF_LSB_SPI3_FAULT = 8;
    localparam int IPF_LSB_UART4_TX = 4;
    localparam int IPF_LSB_UART4_RX = 0;
    localparam int IPF_LSB_CAPTURE9 = 4;
    localparam int IPF_LSB_COMPARE9 = 0;

    // implemented bits of each register; all others read zero
    localparam logic [IPF_REG_W-1:0] IPF_MASK_SPI3_UART4 = 16'h7777;
    localparam logic [IPF_REG_W-1:0] IPF_MASK_CAPCMP9 = 16'h0077;

    // ------------------------------------------------------------------
    // field codes
    // ------------------------------------------------------------------
    localparam logic [IPF_PRIO_W-1:0] IPF_PRIO_RESET = 3'h4;
    localparam logic [IPF_PRIO_W-1:0] IPF_PRIO_OFF = 3'h0;
    localparam logic [IPF_PRIO_W-1:0] IPF_PRIO_LOW = 3'h1;
    localparam logic [IPF_PRIO_W-1:0] IPF_PRIO_HIGH = 3'h7;

    localparam int IPF_WAIT_CYCLES = 1;

    typedef struct packed {
        logic [IPF_PRIO_W-1:0] level;
        logic enabled;
        logic is_highest;
        logic is_lowest;
    } ipf_prio_t;

    typedef struct packed {
        ipf_prio_t spi3_event_priority;
        ipf_prio_t spi3_fault_priority;
        ipf_prio_t uart4_tx_priority;
        ipf_prio_t uart4_rx_priority;
        ipf_prio_t capture9_priority;
        ipf_prio_t compare9_priority;
    } ipf_prio_set_t;

endpackage

`default_nettype wire

/* src/ipf_field_decode.sv */
/*
 * Decodes one 3-bit priority field into level and qualifier flags.
 * Assumes the field comes straight from a register flip-flop.
 */
`default_nettype none

module ipf_field_decode
    import ipf_pkg::*;
(
    input wire logic [IPF_PRIO_W-1:0] field,
    output ipf_prio_t prio
);

    always_comb begin
        prio.level = field;
        prio.enabled = (field != IPF_PRIO_OFF);
        prio.is_highest = (field == IPF_PRIO_HIGH);
        prio.is_lowest = (field == IPF_PRIO_LOW);
    end

endmodule // ipf_field_decode

`default_nettype wire

/* src/ipf_regs.sv */
/*
 * Two 16-bit interrupt priority registers behind an Avalon-MM slave,
 * with decoded priority outputs for six sources.
 * Assumes a master that holds its request until waitrequest is low.
 */
`default_nettype none

module ipf_regs
    import ipf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [IPF_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [IPF_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [IPF_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    output ipf_prio_set_t prio_out,
    output logic [IPF_NSRC-1:0] src_enabled
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [IPF_REG_W-1:0] reg_a_ff;
    logic [IPF_REG_W-1:0] reg_b_ff;
    logic [IPF_REG_W-1:0] nxt_reg_a;
    logic [IPF_REG_W-1:0] nxt_reg_b;
    logic ack_ff;
    logic [IPF_DATA_W-1:0] rdata_ff;
    logic [1:0] resp_ff;
    logic [IPF_REG_W-1:0] wmask;
    logic hit_a;
    logic hit_b;
    logic req;
    logic acc;

    // widen before shifting so the upper fields are not lost
    localparam logic [IPF_REG_W-1:0] RESET_A =
        (IPF_REG_W'(IPF_PRIO_RESET) << IPF_LSB_SPI3_EVENT)
        | (IPF_REG_W'(IPF_PRIO_RESET) << IPF_LSB_SPI3_FAULT)
        | (IPF_REG_W'(IPF_PRIO_RESET) << IPF_LSB_UART4_TX)
        | (IPF_REG_W'(IPF_PRIO_RESET) << IPF_LSB_UART4_RX);
    localparam logic [IPF_REG_W-1:0] RESET_B =
        (IPF_REG_W'(IPF_PRIO_RESET) << IPF_LSB_CAPTURE9)
        | (IPF_REG_W'(IPF_PRIO_RESET) << IPF_LSB_COMPARE9);

    assign req = (avs_read || avs_write) && !ack_ff;
    assign acc = (avs_read || avs_write) && ack_ff;
    assign hit_a = (avs_address == IPF_OFS_SPI3_UART4);
    assign hit_b = (avs_address == IPF_OFS_CAPCMP9);
    assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // ------------------------------------------------------------------
    // write path
    // ------------------------------------------------------------------
    // the write waits for the accepting cycle, so it lands on the very
    // edge at which the master sees waitrequest low and no earlier
    always_comb begin
        nxt_reg_a = reg_a_ff;
        nxt_reg_b = reg_b_ff;
        if (acc && avs_write && hit_a) begin
            nxt_reg_a = ((reg_a_ff & ~wmask)
                | (avs_writedata[IPF_REG_W-1:0] & wmask))
                & IPF_MASK_SPI3_UART4;
        end
        if (acc && avs_write && hit_b) begin
            nxt_reg_b = ((reg_b_ff & ~wmask)
                | (avs_writedata[IPF_REG_W-1:0] & wmask))
                & IPF_MASK_CAPCMP9;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_a_ff <= RESET_A;
            reg_b_ff <= RESET_B;
        end else begin
            reg_a_ff <= nxt_reg_a;
            reg_b_ff <= nxt_reg_b;
        end
    end

    // ------------------------------------------------------------------
    // bus handshake and read path
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            resp_ff <= 2'h0;
        end else begin
            ack_ff <= req;
            if (req) begin
                resp_ff <= (hit_a || hit_b) ? 2'h0 : 2'h3;
                rdata_ff <= 32'h0000_0000;
                if (avs_read && hit_a) begin
                    rdata_ff <= {16'h0000,
                        reg_a_ff & IPF_MASK_SPI3_UART4};
                end
                if (avs_read && hit_b) begin
                    rdata_ff <= {16'h0000,
                        reg_b_ff & IPF_MASK_CAPCMP9};
                end
            end
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
    assign avs_readdata = rdata_ff;
    assign avs_response = resp_ff;

    // ------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------
    ipf_field_decode u_spi3_event (
        .field(reg_a_ff[IPF_LSB_SPI3_EVENT +: IPF_PRIO_W]),
        .prio(prio_out.spi3_event_priority)
    );
    ipf_field_decode u_spi3_fault (
        .field(reg_a_ff[IPF_LSB_SPI3_FAULT +: IPF_PRIO_W]),
        .prio(prio_out.spi3_fault_priority)
    );
    ipf_field_decode u_uart4_tx (
        .field(reg_a_ff[IPF_LSB_UART4_TX +: IPF_PRIO_W]),
        .prio(prio_out.uart4_tx_priority)
    );
    ipf_field_decode u_uart4_rx (
        .field(reg_a_ff[IPF_LSB_UART4_RX +: IPF_PRIO_W]),
        .prio(prio_out.uart4_rx_priority)
    );
    ipf_field_decode u_capture9 (
        .field(reg_b_ff[IPF_LSB_CAPTURE9 +: IPF_PRIO_W]),
        .prio(prio_out.capture9_priority)
    );
    ipf_field_decode u_compare9 (
        .field(reg_b_ff[IPF_LSB_COMPARE9 +: IPF_PRIO_W]),
        .prio(prio_out.compare9_priority)
    );

    // a disabled source must never reach the arbiter
    assign src_enabled = {prio_out.spi3_event_priority.enabled,
        prio_out.spi3_fault_priority.enabled,
        prio_out.uart4_tx_priority.enabled,
        prio_out.uart4_rx_priority.enabled,
        prio_out.capture9_priority.enabled,
        prio_out.compare9_priority.enabled};

endmodule // ipf_regs

`default_nettype wire

/* tb/ipf_regs_sva.sv */
/* Port checker for ipf_regs.
   Assumes it is bound to ipf_regs on one clock. */
`default_nettype none
module ipf_regs_sva
    import ipf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [IPF_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [IPF_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [IPF_DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    input wire ipf_prio_set_t prio_out,
    input wire logic [IPF_NSRC-1:0] src_enabled
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [31:0] wd_ff;
    wire logic wa = avs_write && !avs_waitrequest;
    wire logic ra = avs_read && !avs_waitrequest;
    wire logic wa0 = wa && avs_address == IPF_OFS_SPI3_UART4;
    wire logic wa4 = wa && avs_address == IPF_OFS_CAPCMP9;
    // the write lands on the accepting edge, so compare one cycle on
    always_ff @(posedge sys_clk) wd_ff <= avs_writedata;
    sequence s_ack;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    chk_one_wait: assert property (
        (avs_read || avs_write) && avs_waitrequest |-> s_ack)
        else $error("wait is not one cycle");
    chk_reset_level: assert property ($fell(rst) |->
        src_enabled == 6'h3F && prio_out.compare9_priority.level == 3'h4)
        else $error("reset level wrong");
    chk_top_code: assert property (prio_out.uart4_tx_priority.is_highest
        == (prio_out.uart4_tx_priority.level == 3'h7))
        else $error("highest flag wrong");
    chk_low_code: assert property (prio_out.spi3_fault_priority.is_lowest
        == (prio_out.spi3_fault_priority.level == 3'h1))
        else $error("lowest flag wrong");
    chk_off_code: assert property (src_enabled[2] ==
        (prio_out.uart4_rx_priority.level != 3'h0))
        else $error("enable flag wrong");
    chk_event_field: assert property (wa0 && avs_byteenable[1] |=>
        prio_out.spi3_event_priority.level == wd_ff[14:12])
        else $error("event field wrong");
    chk_capture_field: assert property (wa4 && avs_byteenable[0] |=>
        prio_out.capture9_priority.level == wd_ff[6:4])
        else $error("capture field wrong");
    chk_compare_field: assert property (wa4 && avs_byteenable[0] |=>
        prio_out.compare9_priority.level == wd_ff[2:0])
        else $error("compare field wrong");
    chk_unused_zero: assert property (ra |->
        (avs_readdata & ~{16'h0, (avs_address == IPF_OFS_CAPCMP9)
        ? IPF_MASK_CAPCMP9 : IPF_MASK_SPI3_UART4}) == 32'h0)
        else $error("unused bits not zero");
endmodule // ipf_regs_sva
bind ipf_regs ipf_regs_sva u_sva (.sys_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .avs_response, .prio_out, .src_enabled);
`default_nettype wire

/* tb/tb.sv */
/* Self-checking bench for ipf_regs against a register model.
   Assumes the port checker is bound in from its own file. */
`default_nettype none
module tb
    import ipf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst = 1, avs_read = 0, avs_write = 0;
    logic [IPF_ADDR_W-1:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, rd;
    logic [3:0] avs_byteenable = '0;
    logic avs_waitrequest;
    logic [1:0] avs_response, rsp;
    ipf_prio_set_t prio_out;
    logic [5:0] src_enabled;
    int bad_count = 0, tests_run = 0, cyc = 0, mdl[2];
    ipf_regs dut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .avs_response, .prio_out, .src_enabled);
    initial forever #2 sys_clk = ~sys_clk;
    task automatic report_and_stop;
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            report_and_stop;
        end
    end
    task automatic check_word(logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_prio(logic [6:0] got, logic [6:0] exp);
        check_word({25'h0, got}, {25'h0, exp});
    endtask
    // entered on a rising edge; leaves the request up so ops run back to back
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d, logic [3:0] be);
        logic ok;
        logic [31:0] m;
        ok = a inside {4'h0, 4'h4};
        m = {16'h0, {8{be[1]}}, {8{be[0]}}} & (a[2] ? 32'h77 : 32'h7777);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        rsp = avs_response;
        if (!w)
            check_word(rd, ok ? mdl[a[2]] : 32'h0);
        check_word({30'h0, rsp}, ok ? 32'h0 : 32'h3);
        if (w && ok)
            mdl[a[2]] = (mdl[a[2]] & ~m) | (d & m);
    endtask
    // drops the request and lets the last accepted write land first
    task automatic check_levels;
        logic [2:0] e;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
        for (int s = 0; s < 6; s++) begin
            e = 3'(mdl[s / 4] >> (s < 4 ? 12 - 4 * s : 20 - 4 * s));
            check_prio({prio_out[35 - 6 * s -: 6], src_enabled[5 - s]},
                {e, e != 0, e == 7, e == 1, e != 0});
        end
    endtask
    initial begin
        mdl = '{32'h4444, 32'h44};
        rd = $urandom(32'h43A57B1D);
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        check_levels;
        for (int a = 0; a < 16; a += 4)
            bus(1'b0, 4'(a), 32'h0, 4'hF);
        $display("test reset values done");
        // every code, with the unused bits set to show they stay zero
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, 4'h0, 32'hFFFF8888 | 32'h1111 * c, 4'hF);
            bus(1'b1, 4'h4, 32'hFFFFFF88 | 32'h11 * c, 4'hF);
            check_levels;
            bus(1'b0, 4'h0, 32'h0, 4'hF);
            bus(1'b0, 4'h4, 32'h0, 4'hF);
        end
        $display("test field codes done");
        repeat (30)
            bus(1'($urandom_range(1)), 4'($urandom_range(3) * 4), $urandom,
                4'($urandom));
        check_levels;
        $display("test random lanes done");
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        mdl = '{32'h4444, 32'h44};
        check_levels;
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        bus(1'b0, 4'h4, 32'h0, 4'hF);
        $display("test mid reset done");
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
        report_and_stop;
    end
endmodule // tb
`default_nettype wire
